// file: src/cfgl_clkgen.sv
// Purpose: Symmetric divider making the passive configuration clock
// Assumes: Shares pclk with the sequencer
// Notes: Stops only in its low phase, so no runt pulse
`default_nettype none
module cfgl_clkgen #(
   parameter int HALF_W = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic run,
   input wire logic [HALF_W-1:0] half,
   output logic cfg_clock_q,
   output logic fall_p
);
   initial
   begin
      if (HALF_W < 2)
      begin
         $error("cfgl_clkgen: HALF_W too small");
      end
   end

   logic [HALF_W-1:0] cnt_q;
   logic [HALF_W-1:0] cnt_d;
   logic cfg_clock_d;
   logic flip;

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb
   begin
      cnt_d = cnt_q;
      cfg_clock_d = cfg_clock_q;
      flip = 1'b0;
      fall_p = 1'b0;
      if (run || cfg_clock_q)
      begin
         flip = (cnt_q + 1'b1 >= half);
         cnt_d = flip ? '0 : cnt_q + 1'b1;
         cfg_clock_d = flip ? ~cfg_clock_q : cfg_clock_q;
         fall_p = flip && cfg_clock_q;
      end
      else
      begin
         cnt_d = '0;
      end
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt_q <= '0;
         cfg_clock_q <= 1'b0;
      end
      else if (ce)
      begin
         cnt_q <= cnt_d;
         cfg_clock_q <= cfg_clock_d;
      end
   end
endmodule // cfgl_clkgen
`default_nettype wire

// file: src/cfgl_host.sv
// Purpose: Host sequencer loading a configuration bitstream into a device
// Assumes: pclk 40 MHz, APB slave for software, device pins on the other side
// Notes: Drives trigger, passive clock and data; watches the done flag
//
// Chosen here: register access over APB and the address map.
`include "cfgl_params.svh"
`default_nettype none
// Function
// - The trigger output is held low for at least 320 ns to start a load.
// - User mode is reported only 25 us after the done flag has risen.
// - The user-side reset stays asserted until the post-done delay has run out.
// - In joint-test-port mode the post-done delay starts once done and user entry coincide.
// - In a parallel chain of width two or four the divide-by-four setting is forced.
// - A one-bit passive clock stays at or below 10 MHz or 12.5 MHz by grade.
// - A 2- to 8-bit bus runs at most 50 MHz and a 16- or 32-bit bus at most 100 MHz.
// - Each clock phase lasts at least 0.48 of the least period of the chosen width.
// - The first data word follows the trigger release by at least 1.2 us.
// - The worst user-mode delay is the trigger-to-threshold time plus the least delay.
// - A chain master adds 1344 over the bus width clock periods to that worst delay.
module cfgl_host #(
   parameter int HALF_W = 8,
   parameter int AB_CYC = 40
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic config_complete_flag,
   output logic reconfig_n,
   output logic cfg_clock,
   output logic [31:0] cfg_data,
   output logic active_mode,
   output logic clock_divide_by_eight,
   output logic user_rst_n
);
   initial
   begin
      if (HALF_W < 2 || HALF_W > 8 || AB_CYC < 0)
      begin
         $error("cfgl_host: unsupported parameters");
      end
   end

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [HALF_W-1:0] half_min(input logic [2:0] wid, input logic lp);
      int f;
      f = (wid == 3'h0) ? (lp ? `CFGL_X1_LP_KHZ : `CFGL_X1_KHZ) :
          (wid <= 3'h3) ? `CFGL_X8_KHZ : `CFGL_X32_KHZ;
      half_min = HALF_W'((`CFGL_PCLK_KHZ + 2 * f - 1) / (2 * f));
   endfunction

   function automatic logic [31:0] slice(input logic [31:0] w, input logic [2:0] wid);
      logic [31:0] m;
      m = (wid >= 3'h5) ? 32'hFFFF_FFFF : ((32'h0000_0001 << (6'h01 << wid)) - 32'h0000_0001);
      slice = w & m;
   endfunction

   function automatic logic [2:0] clamp_wid(input logic [2:0] wid);
      clamp_wid = (wid > 3'h5) ? 3'h5 : wid;
   endfunction

   // ----------------------------------------
   // Pin synchroniser
   // ----------------------------------------
   logic done_m_q;
   logic done_s_q;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         done_m_q <= 1'b0;
         done_s_q <= 1'b0;
      end
      else if (ce)
      begin
         done_m_q <= config_complete_flag;
         done_s_q <= done_m_q;
      end
   end

   // ----------------------------------------
   // Register and sequence state
   // ----------------------------------------
   logic [31:0] ctrl_q, ctrl_d;
   logic [31:0] prdata_q, prdata_d;
   logic pready_q, pready_d;
   logic pslverr_q, pslverr_d;
   cfgl_pkg::cfgl_state_e st_q, st_d;
   logic [15:0] cnt_q, cnt_d;
   logic [31:0] word_q, word_d;
   logic word_v_q, word_v_d;
   logic [5:0] left_q, left_d;
   logic [31:0] data_q, data_d;
   logic reconfig_n_q, reconfig_n_d;
   logic user_rst_n_q, user_rst_n_d;
   logic active_q, active_d;
   logic clock_divide_by_eight_q, clock_divide_by_eight_d;
   logic start_p;
   logic [2:0] wid;
   logic [HALF_W-1:0] half_eff;
   logic run;
   logic fall_p;
   logic acc;
   logic commit;
   logic stall;
   logic [31:0] tmax;
   logic [31:0] cck_per;

   assign wid = clamp_wid(ctrl_q[`CFGL_CTRL_WID_HI:`CFGL_CTRL_WID_LO]);
   assign acc = psel && penable;
   assign commit = acc && pready_q;
   assign stall = pwrite && (paddr == `CFGL_DATA_OFS) && word_v_q;
   assign start_p = commit && pwrite && (paddr == `CFGL_CTRL_OFS) && pwdata[`CFGL_CTRL_START];
   assign run = word_v_q && (st_q == cfgl_pkg::CFGL_LOAD) && !active_q;

   // Equal phases from one half count
   always_comb
   begin
      half_eff = HALF_W'(ctrl_q[`CFGL_CTRL_HALF_HI:`CFGL_CTRL_HALF_LO]);
      if (half_eff < half_min(wid, ctrl_q[`CFGL_CTRL_LOWPWR]))
      begin
         half_eff = half_min(wid, ctrl_q[`CFGL_CTRL_LOWPWR]);
      end
   end

   always_comb
   begin
      cck_per = 32'(half_eff) << 1;
      tmax = 32'(`CFGL_USER_CYC) + 32'(AB_CYC);
      if (ctrl_q[`CFGL_CTRL_MASTER])
      begin
         tmax = tmax + ((32'(`CFGL_CHAIN_BITS) >> wid) * cck_per);
      end
   end

   cfgl_clkgen #(
      .HALF_W(HALF_W)
   ) u_clk (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .run(run),
      .half(half_eff),
      .cfg_clock_q(cfg_clock),
      .fall_p(fall_p)
   );

   // ----------------------------------------
   // APB slave
   // ----------------------------------------
   always_comb
   begin
      ctrl_d = ctrl_q;
      prdata_d = prdata_q;
      pready_d = 1'b0;
      pslverr_d = 1'b0;
      // Data writes wait while a word is still going out
      if (acc && !pready_q && !stall)
      begin
         pready_d = 1'b1;
         prdata_d = 32'h0000_0000;
         case (paddr)
            `CFGL_CTRL_OFS: prdata_d = ctrl_q;
            `CFGL_STAT_OFS: prdata_d = {26'h000_0000, word_v_q, user_rst_n_q, done_s_q, st_q};
            `CFGL_DATA_OFS: prdata_d = 32'h0000_0000;
            `CFGL_TMAX_OFS: prdata_d = tmax;
            default: pslverr_d = 1'b1;
         endcase
         if (pwrite && (paddr == `CFGL_STAT_OFS || paddr == `CFGL_TMAX_OFS))
         begin
            pslverr_d = 1'b1;
         end
      end
      if (commit && pwrite && paddr == `CFGL_CTRL_OFS)
      begin
         ctrl_d = pwdata & `CFGL_CTRL_WMASK;
      end
   end

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   always_comb
   begin
      st_d = st_q;
      cnt_d = cnt_q;
      word_d = word_q;
      word_v_d = word_v_q;
      left_d = left_q;
      data_d = data_q;
      reconfig_n_d = 1'b1;
      user_rst_n_d = 1'b0;
      active_d = active_q;
      clock_divide_by_eight_d = clock_divide_by_eight_q;
      case (st_q)
         cfgl_pkg::CFGL_IDLE:
         begin
            cnt_d = '0;
         end
         cfgl_pkg::CFGL_TRIG:
         begin
            reconfig_n_d = 1'b0;
            cnt_d = cnt_q + 16'h0001;
            if (cnt_q >= 16'(`CFGL_TRIG_CYC - 1))
            begin
               reconfig_n_d = 1'b1;
               cnt_d = '0;
               st_d = cfgl_pkg::CFGL_DMIN;
            end
         end
         cfgl_pkg::CFGL_DMIN:
         begin
            cnt_d = cnt_q + 16'h0001;
            if (cnt_q >= 16'(`CFGL_DMIN_CYC - 1))
            begin
               cnt_d = '0;
               st_d = cfgl_pkg::CFGL_LOAD;
            end
         end
         cfgl_pkg::CFGL_LOAD:
         begin
            // Done from the device ends loading
            if (done_s_q)
            begin
               cnt_d = '0;
               st_d = cfgl_pkg::CFGL_POST;
            end
         end
         cfgl_pkg::CFGL_POST:
         begin
            // In test-port mode the delay counts only after user entry
            if (!done_s_q)
            begin
               st_d = cfgl_pkg::CFGL_LOAD;
            end
            else if (!ctrl_q[`CFGL_CTRL_JTAG] || ctrl_q[`CFGL_CTRL_UINSTR])
            begin
               cnt_d = cnt_q + 16'h0001;
               if (cnt_q >= 16'(`CFGL_USER_CYC - 1))
               begin
                  st_d = cfgl_pkg::CFGL_USER;
               end
            end
         end
         cfgl_pkg::CFGL_USER:
         begin
            user_rst_n_d = 1'b1;
            if (!done_s_q)
            begin
               user_rst_n_d = 1'b0;
               st_d = cfgl_pkg::CFGL_IDLE;
            end
         end
         default:
         begin
            st_d = cfgl_pkg::CFGL_IDLE;
         end
      endcase
      // Word shifting, least significant slice first
      if (fall_p)
      begin
         if (left_q > 6'h01)
         begin
            word_d = word_q >> (6'h01 << wid);
            data_d = slice(word_q >> (6'h01 << wid), wid);
            left_d = left_q - 6'h01;
         end
         else
         begin
            word_v_d = 1'b0;
         end
      end
      if (commit && pwrite && paddr == `CFGL_DATA_OFS)
      begin
         word_d = pwdata;
         word_v_d = 1'b1;
         left_d = 6'(32 >> wid);
         data_d = slice(pwdata, wid);
      end
      if (start_p)
      begin
         // Restart drops any half-sent word
         st_d = cfgl_pkg::CFGL_TRIG;
         cnt_d = '0;
         word_v_d = 1'b0;
         reconfig_n_d = 1'b0;
         user_rst_n_d = 1'b0;
         active_d = ctrl_q[`CFGL_CTRL_ACTIVE];
         // Divider select, forced for x2 and x4
         clock_divide_by_eight_d = ctrl_q[`CFGL_CTRL_CLOCK_DIVIDE_BY_EIGHT] && !(wid == 3'h1 || wid == 3'h2);
      end
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_q <= `CFGL_CTRL_RST;
         prdata_q <= 32'h0000_0000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         st_q <= cfgl_pkg::CFGL_IDLE;
         cnt_q <= 16'h0000;
         word_q <= 32'h0000_0000;
         word_v_q <= 1'b0;
         left_q <= 6'h00;
         data_q <= 32'h0000_0000;
         reconfig_n_q <= 1'b1;
         user_rst_n_q <= 1'b0;
         active_q <= 1'b0;
         clock_divide_by_eight_q <= 1'b0;
      end
      else if (ce)
      begin
         ctrl_q <= ctrl_d;
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
         st_q <= st_d;
         cnt_q <= cnt_d;
         word_q <= word_d;
         word_v_q <= word_v_d;
         left_q <= left_d;
         data_q <= data_d;
         reconfig_n_q <= reconfig_n_d;
         user_rst_n_q <= user_rst_n_d;
         active_q <= active_d;
         clock_divide_by_eight_q <= clock_divide_by_eight_d;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign reconfig_n = reconfig_n_q;
   assign cfg_data = data_q;
   assign active_mode = active_q;
   assign clock_divide_by_eight = clock_divide_by_eight_q;
   assign user_rst_n = user_rst_n_q;
endmodule // cfgl_host
`default_nettype wire

// file: src/cfgl_params.svh
// Purpose: Constants of the configuration load sequencer (host end)
// Assumes: pclk at 40 MHz
// Notes: Times in their own units, cycle counts derived from them
`ifndef CFGL_PARAMS_SVH
`define CFGL_PARAMS_SVH

// ----------------------------------------
// Clock
// ----------------------------------------
`define CFGL_PCLK_NS 25
`define CFGL_PCLK_KHZ 40000

// ----------------------------------------
// Sequencing times
// ----------------------------------------
`define CFGL_TRIG_NS 320
`define CFGL_TRIG_CYC ((`CFGL_TRIG_NS + `CFGL_PCLK_NS - 1) / `CFGL_PCLK_NS)
`define CFGL_DMIN_NS 1200
`define CFGL_DMIN_CYC ((`CFGL_DMIN_NS + `CFGL_PCLK_NS - 1) / `CFGL_PCLK_NS)
`define CFGL_USER_NS 25000
`define CFGL_USER_CYC ((`CFGL_USER_NS + `CFGL_PCLK_NS - 1) / `CFGL_PCLK_NS)
`define CFGL_CHAIN_BITS 1344

// ----------------------------------------
// Passive clock limits
// ----------------------------------------
`define CFGL_X1_LP_KHZ 10000
`define CFGL_X1_KHZ 12500
`define CFGL_X8_KHZ 50000
`define CFGL_X32_KHZ 100000

// ----------------------------------------
// Register map
// ----------------------------------------
`define CFGL_CTRL_OFS 12'h000
`define CFGL_STAT_OFS 12'h004
`define CFGL_DATA_OFS 12'h008
`define CFGL_TMAX_OFS 12'h00C
`define CFGL_CTRL_START 0
`define CFGL_CTRL_WID_LO 1
`define CFGL_CTRL_WID_HI 3
`define CFGL_CTRL_LOWPWR 4
`define CFGL_CTRL_ACTIVE 5
`define CFGL_CTRL_CLOCK_DIVIDE_BY_EIGHT 6
`define CFGL_CTRL_JTAG 7
`define CFGL_CTRL_UINSTR 8
`define CFGL_CTRL_MASTER 9
`define CFGL_CTRL_HALF_LO 16
`define CFGL_CTRL_HALF_HI 23
`define CFGL_CTRL_RST 32'h0001_0000
`define CFGL_CTRL_WMASK 32'h00FF_03FE

`endif

// file: src/cfgl_pkg.sv
// Purpose: Types of the configuration load sequencer
// Assumes: Nothing
// Notes: Constants live in cfgl_params.svh
`default_nettype none
package cfgl_pkg;
   typedef enum logic [2:0] {
      CFGL_IDLE,
      CFGL_TRIG,
      CFGL_DMIN,
      CFGL_LOAD,
      CFGL_POST,
      CFGL_USER
   } cfgl_state_e;
endpackage
`default_nettype wire

// file: verification/cfgl_dev_model.sv
// Purpose: Device end of the load, passive mode
// Assumes: Slices are taken on the rising configuration clock
// Notes: Payload is not decoded; done follows a fixed edge count
`default_nettype none
module cfgl_dev_model #(
   parameter int NEED = 32
) (
   input wire logic reconfig_n,
   input wire logic cfg_clock,
   output logic config_complete_flag
);
   timeunit 1ns;
   timeprecision 1ps;
   realtime t_low = 0.0;
   int n_edge = 0;
   initial config_complete_flag = 1'b0;
   always @(negedge reconfig_n)
      t_low = $realtime;
   always @(posedge reconfig_n)
   begin
      if ($realtime - t_low >= 320.0)
      begin
         n_edge = 0;
         config_complete_flag = 1'b0;
      end
   end
   always @(posedge cfg_clock)
   begin
      n_edge++;
      if (reconfig_n && n_edge >= NEED)
         config_complete_flag = 1'b1;
   end
endmodule // cfgl_dev_model
`default_nettype wire

// file: verification/cfgl_host_props.sv
// Purpose: Port assertions for the configuration load sequencer
// Assumes: ce high; mode bits written before each start
// Notes: Width and test-port bits are copied from CTRL writes
`include "cfgl_params.svh"
`default_nettype none
module cfgl_host_props #(
   parameter int HALF_W = 8,
   parameter int AB_CYC = 40
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic config_complete_flag,
   input wire logic reconfig_n,
   input wire logic cfg_clock,
   input wire logic [31:0] cfg_data,
   input wire logic active_mode,
   input wire logic clock_divide_by_eight,
   input wire logic user_rst_n
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] wid_q, wid_d;
   logic jtag_q, jtag_d, uin_q, uin_d, ck_q, wr, dc_inc;
   logic [1:0] ph_q, ph_d;
   logic [5:0] rel_q, rel_d;
   logic [10:0] dc_q, dc_d;
   // ----------------------------------------
   // Helper state
   // ----------------------------------------
   always_comb
   begin
      wr = psel && penable && pready && pwrite && paddr == `CFGL_CTRL_OFS;
      wid_d = wr ? pwdata[3:1] : wid_q;
      jtag_d = wr ? pwdata[`CFGL_CTRL_JTAG] : jtag_q;
      uin_d = wr ? pwdata[`CFGL_CTRL_UINSTR] : uin_q;
      ph_d = (cfg_clock != ck_q) ? 2'h1 : ph_q + {1'b0, ph_q != 2'h3};
      rel_d = !reconfig_n ? 6'h00 : rel_q + {5'h00, rel_q != 6'h3F};
      // Held while the test port lacks user entry
      dc_inc = dc_q != 11'h7FF && (!jtag_q || uin_q);
      dc_d = !config_complete_flag ? 11'h000 : dc_q + {10'h000, dc_inc};
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wid_q <= 3'h0;
         jtag_q <= 1'b0;
         uin_q <= 1'b0;
         ck_q <= 1'b0;
         ph_q <= 2'h0;
         rel_q <= 6'h00;
         dc_q <= 11'h000;
      end
      else
      begin
         wid_q <= wid_d;
         jtag_q <= jtag_d;
         uin_q <= uin_d;
         ck_q <= cfg_clock;
         ph_q <= ph_d;
         rel_q <= rel_d;
         dc_q <= dc_d;
      end
   end
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   chk_trig_width: assert property ($fell(reconfig_n) |->
      (!reconfig_n)[*8] ##1 (!reconfig_n)[*5]) else $error("trigger pulse too short");
   chk_first_data: assert property ($rose(cfg_clock) |-> rel_q >= 6'd48)
      else $error("data clocked too soon after trigger");
   chk_user_wait: assert property ($rose(user_rst_n) |-> dc_q >= 11'd1000)
      else $error("user mode before post-done delay");
   chk_user_needs_done: assert property ((!config_complete_flag)[*4] |-> !user_rst_n)
      else $error("user reset released without done");
   chk_entry_gate: assert property (jtag_q && !uin_q |-> !$rose(user_rst_n))
      else $error("user mode without entry instruction");
   // ceiling held through the phase floor
   chk_phase_x1: assert property ((cfg_clock != ck_q) && wid_q == 3'h0 |-> ph_q >= 2'd2)
      else $error("one-bit clock phase too short");
   chk_div_forced: assert property (active_mode && wid_q inside {3'h1, 3'h2} |->
      !clock_divide_by_eight) else $error("divider not forced to four");
   chk_active_quiet: assert property (active_mode |-> !$rose(cfg_clock))
      else $error("clock driven in active mode");
   cover property ($rose(user_rst_n));
   cover property ($rose(cfg_clock) && wid_q == 3'h0);
   cover property (active_mode && !clock_divide_by_eight);
endmodule // cfgl_host_props
bind cfgl_host cfgl_host_props #(.HALF_W(HALF_W), .AB_CYC(AB_CYC)) u_props (.pclk, .presetn,
   .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
   .config_complete_flag, .reconfig_n, .cfg_clock, .cfg_data, .active_mode,
   .clock_divide_by_eight, .user_rst_n);
`default_nettype wire

// file: verification/tb_top.sv
// Purpose: Self-checking bench for the configuration load sequencer
// Assumes: Device model raises done after 32 clock edges
// Notes: One monitor compares reads and slices against queues
`include "cfgl_params.svh"
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, cfg_data, word;
   logic [31:0] mask = 32'h0000_0001;
   logic [2:0] wd = 3'h0;
   logic pready, pslverr, reconfig_n, cfg_clock, active_mode, clock_divide_by_eight;
   logic user_rst_n, config_complete_flag;
   logic ck_prev = 1'b0;
   logic [32:0] q_rd[$];
   logic [31:0] q_sl[$];
   int n_mismatch = 0;
   int check_count = 0;
   int seed = 32'h7303;
   int i;
   always #12.5 pclk = ~pclk;
   cfgl_host #(.HALF_W(8), .AB_CYC(40)) uut (.pclk, .presetn, .ce(1'b1), .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .config_complete_flag,
      .reconfig_n, .cfg_clock, .cfg_data, .active_mode, .clock_divide_by_eight, .user_rst_n);
   cfgl_dev_model #(.NEED(32)) dev (.reconfig_n, .cfg_clock, .config_complete_flag);
   // ----------------------------------------
   // Checking
   // ----------------------------------------
   task automatic check(input logic [32:0] seen, input logic [32:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run;
      if (n_mismatch == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   always @(posedge pclk)
   begin
      if (pready === 1'b1)
         check({pslverr, pwrite ? 32'h0 : prdata}, q_rd.pop_front());
      if (cfg_clock === 1'b1 && ck_prev === 1'b0)
         check({1'b0, cfg_data & mask}, {1'b0, q_sl.pop_front()});
      ck_prev = cfg_clock;
   end
   // ----------------------------------------
   // Drivers
   // ----------------------------------------
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
      input logic [32:0] exp);
      int n;
      n = 0;
      q_rd.push_back(exp);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 4000);
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 4000)
      begin
         n_mismatch++;
         complete_run();
      end
   endtask
   task automatic wait_for(input logic want, input int lim);
      int n;
      n = 0;
      while (user_rst_n !== want && n < lim)
      begin
         @(posedge pclk);
         n++;
      end
      if (n >= lim)
      begin
         n_mismatch++;
         complete_run();
      end
   endtask
   // Mode bits first, then the start
   task automatic cfg(input logic [31:0] v);
      wd = v[3:1];
      mask = (wd == 3'h5) ? 32'hFFFF_FFFF : (32'h1 << (32'h1 << wd)) - 32'h1;
      apb(1'b1, `CFGL_CTRL_OFS, v, 33'h0);
      apb(1'b1, `CFGL_CTRL_OFS, v | 32'h1, 33'h0);
   endtask
   task automatic send;
      word = $random(seed);
      for (i = 0; i < (32 >> wd); i++)
         q_sl.push_back((word >> (i << wd)) & mask);
      apb(1'b1, `CFGL_DATA_OFS, word, 33'h0);
   endtask
   initial
   begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `CFGL_CTRL_OFS, 32'h0, {1'b0, `CFGL_CTRL_RST});
      apb(1'b0, `CFGL_STAT_OFS, 32'h0, 33'h0);
      apb(1'b0, `CFGL_TMAX_OFS, 32'h0, 33'd1040);
      apb(1'b0, 12'h010, 32'h0, {1'b1, 32'h0});
      apb(1'b1, `CFGL_STAT_OFS, 32'h5, {1'b1, 32'h0});
      for (int w = 0; w < 6; w++)
      begin
         apb(1'b1, `CFGL_CTRL_OFS, 32'h0001_0200 | (w << 1), 33'h0);
         apb(1'b0, `CFGL_TMAX_OFS, 32'h0, 33'(1040 + (1344 >> w) * 2 * (w == 0 ? 2 : 1)));
      end
      cfg(32'h0002_000A);
      repeat (32) send();
      wait_for(1'b1, 1500);
      apb(1'b0, `CFGL_STAT_OFS, 32'h0, 33'h1D);
      // Restart from user mode, low-power one-bit, test port
      cfg(32'h0001_0090);
      wait_for(1'b0, 20);
      send();
      repeat (1100) @(posedge pclk);
      apb(1'b0, `CFGL_STAT_OFS, 32'h0, 33'h0C);
      apb(1'b1, `CFGL_CTRL_OFS, 32'h0001_0190, 33'h0);
      wait_for(1'b1, 1200);
      cfg(32'h0001_0062);
      @(posedge pclk);
      check({31'h0, active_mode, clock_divide_by_eight}, 33'h2);
      cfg(32'h0001_0066);
      @(posedge pclk);
      check({31'h0, active_mode, clock_divide_by_eight}, 33'h3);
      check(33'(q_sl.size()), 33'h0);
      complete_run();
   end
endmodule // tb_top
`default_nettype wire
